//--- pkg/bpsc_pkg.sv
/*
 Package for the primary status and class code register slice of a bridge.
 Assumes dword-aligned configuration offsets on the primary bus.
*/
`default_nettype none
package bpsc_pkg;
	localparam logic [7:0] BPSC_OFS_STATUS = 8'h04;
	localparam logic [7:0] BPSC_OFS_CLASS = 8'h08;
	localparam logic [7:0] BPSC_OFS_CMD = 8'h04;
	localparam int BPSC_BIT_PAR_ERR = 31;
	localparam int BPSC_BIT_SYSERR = 30;
	localparam int BPSC_BIT_GOT_MA = 29;
	localparam int BPSC_BIT_GOT_TA = 28;
	localparam int BPSC_BIT_GAVE_TA = 27;
	localparam int BPSC_BIT_MDP = 24;
	localparam int BPSC_BIT_PARITY_RESPONSE_ENABLE = 6;
	localparam int BPSC_BIT_SYSERR_OUTPUT_ENABLE = 8;
	localparam logic [1:0] BPSC_DEVSEL_MEDIUM = 2'h1;
	localparam logic [7:0] BPSC_INTERFACE_FIELD_A_IF = 8'h00;
	localparam logic [7:0] BPSC_SUBCLASS = 8'h04;
	localparam logic [7:0] BPSC_BASECLASS = 8'h06;
	localparam logic [15:0] BPSC_STATUS_RESET = 16'h02b0;
	localparam logic [15:0] BPSC_STATUS_RO_MASK = 16'h06b0;
	localparam logic [15:0] BPSC_STATUS_W1C_MASK = 16'hf900;

	typedef struct packed {
		logic par_err;
		logic syserr;
		logic got_ma;
		logic got_ta;
		logic gave_ta;
		logic mdp;
	} bpsc_evt_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} bpsc_cfg_t;
endpackage : bpsc_pkg
`default_nettype wire

//--- rtl/bpsc_w1c_flag.sv
/*
 One sticky status flag, set by hardware and cleared by writing one.
 Assumes set and clear are single-cycle qualified pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_w1c_flag (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Control
	input wire logic set_evt,
	input wire logic clr_req,
	// State
	output logic flag_ff
);
	logic nxt_flag;

	// Set beats clear so an event in the clearing cycle is kept
	always_comb begin
		nxt_flag = flag_ff;
		if (clr_req)
			nxt_flag = 1'b0;
		if (set_evt)
			nxt_flag = 1'b1;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			flag_ff <= 1'b0;
		else
			flag_ff <= nxt_flag;
	end

	a_set_wins: assert property (@(posedge ref_clk) disable iff (!reset_n)
		set_evt |=> flag_ff)
		else $error("flag lost a set event");
	a_clear_acts: assert property (@(posedge ref_clk) disable iff (!reset_n)
		clr_req && !set_evt |=> !flag_ff)
		else $error("flag not cleared by write of one");
	a_hold_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!clr_req && !set_evt |=> flag_ff == $past(flag_ff))
		else $error("flag changed without cause");
endmodule : bpsc_w1c_flag
`default_nettype wire

//--- rtl/bpsc_regs.sv
/*
 Primary status word and class code dword of a bridge configuration header,
 plus the two command bits that gate status reporting.
 Assumes configuration accesses arrive as one-cycle strobes already decoded
 from primary bus configuration cycles, with active-low byte enables.
*/
// Summary of operation
// - Writing one clears a status flag; writing zero leaves it.
// - Only primary-interface events update this status word.
// - Bit 31 sets on primary address or data parity error.
// - Bit 30 sets when the primary system-error output is driven.
// - Bit 29 sets on master abort received as primary master.
// - Bit 28 sets on target abort received as primary master.
// - Bit 27 sets when bridge signals target abort as target.
// - Bits 26:25 read constant medium device-select timing, read-only.
// - Bit 24 sets when master, parity error seen, and response enabled.
// - Bits 23, 21, 20 read one, read-only.
// - Bits 22 and 19:16 read zero and ignore writes.
// - Revision byte at 0x08 bits 7:0 is read-only.
// - Programming-interface byte reads zero, ignores writes.
// - Subclass byte reads 0x04, read-only.
// - Base class byte reads 0x06, read-only.
// - Parity response bit 6 gates parity-error line and bit 24 parity flag.
// - System-error output driven only while enable bit 8 is one.
`timescale 1ns/1ps
`default_nettype none
module bpsc_regs
	import bpsc_pkg::*;
#(
	parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Configuration access
	input wire bpsc_cfg_t cfg,
	output logic [31:0] rdata_ff,
	output logic rvalid_ff,
	// Primary bus events
	input wire logic pri_is_master,
	input wire logic pri_addr_par_err,
	input wire logic pri_data_par_err,
	input wire logic pri_perr_seen,
	input wire logic pri_got_ma,
	input wire logic pri_got_ta,
	input wire logic pri_gave_ta,
	input wire logic syserr_request,
	input wire logic perr_request,
	// Primary error pins
	output logic primary_syserr_n_ff,
	output logic primary_syserr_oe_ff,
	output logic primary_parity_err_n_ff,
	output logic primary_parity_err_oe_ff,
	// Command bits
	output logic parity_response_enable_ff,
	output logic syserr_output_enable_ff
);
	bpsc_evt_t evt;
	logic [15:0] status;
	logic [5:0] flags;
	logic [5:0] clr;
	logic [31:0] nxt_rdata;
	logic status_wr;
	logic cmd_wr;

	assign status_wr = cfg.wr && cfg.addr == BPSC_OFS_STATUS;
	assign cmd_wr = cfg.wr && cfg.addr == BPSC_OFS_CMD;

	// Command register low byte and high byte, gated by their own enables
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			parity_response_enable_ff <= 1'b0;
			syserr_output_enable_ff <= 1'b0;
		end else if (cmd_wr) begin
			if (!cfg.be_n[0])
				parity_response_enable_ff <= cfg.wdata[BPSC_BIT_PARITY_RESPONSE_ENABLE];
			if (!cfg.be_n[1])
				syserr_output_enable_ff <= cfg.wdata[BPSC_BIT_SYSERR_OUTPUT_ENABLE];
		end
	end

	// Pins are driven only while enabled; each pin follows its request one clock later
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			primary_syserr_n_ff <= 1'b1;
			primary_syserr_oe_ff <= 1'b0;
			primary_parity_err_n_ff <= 1'b1;
			primary_parity_err_oe_ff <= 1'b0;
		end else begin
			primary_syserr_n_ff <= !(syserr_request && syserr_output_enable_ff);
			primary_syserr_oe_ff <= syserr_request && syserr_output_enable_ff;
			primary_parity_err_n_ff <= !(perr_request && parity_response_enable_ff);
			primary_parity_err_oe_ff <= perr_request && parity_response_enable_ff;
		end
	end

	// Only primary-side inputs exist here; secondary status lives elsewhere
	always_comb begin
		evt.par_err = pri_addr_par_err || pri_data_par_err;
		evt.syserr = !primary_syserr_n_ff;
		evt.got_ma = pri_is_master && pri_got_ma;
		evt.got_ta = pri_is_master && pri_got_ta;
		evt.gave_ta = !pri_is_master && pri_gave_ta;
		evt.mdp = pri_is_master && (pri_data_par_err || pri_perr_seen)
			&& parity_response_enable_ff;
	end

	// Flags sit in byte 3 of the dword, so only that enable may clear them
	assign clr = {6{status_wr && !cfg.be_n[3]}} & {cfg.wdata[31:27], cfg.wdata[24]};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_flag
			bpsc_w1c_flag u_flag (
				.ref_clk(ref_clk),
				.reset_n(reset_n),
				.set_evt(evt[gi]),
				.clr_req(clr[gi]),
				.flag_ff(flags[gi])
			);
		end
	endgenerate

	// Constant fields ignore writes by construction
	always_comb begin
		status = BPSC_STATUS_RESET & BPSC_STATUS_RO_MASK;
		status[10:9] = BPSC_DEVSEL_MEDIUM;
		status[15:11] = flags[5:1];
		status[8] = flags[0];
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		if (cfg.addr == BPSC_OFS_STATUS)
			nxt_rdata = {status, 7'h00, syserr_output_enable_ff, 1'b0, parity_response_enable_ff, 6'h00};
		else if (cfg.addr == BPSC_OFS_CLASS)
			nxt_rdata = {BPSC_BASECLASS, BPSC_SUBCLASS, BPSC_INTERFACE_FIELD_A_IF, REVISION};
	end

	// Read data is registered; disabled byte lanes read zero
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= 32'h0000_0000;
			rvalid_ff <= 1'b0;
		end else begin
			rvalid_ff <= cfg.rd;
			rdata_ff <= cfg.rd ? nxt_rdata & {{8{!cfg.be_n[3]}}, {8{!cfg.be_n[2]}},
				{8{!cfg.be_n[1]}}, {8{!cfg.be_n[0]}}} : 32'h0000_0000;
		end
	end

	a_status_const: assert property (@(posedge ref_clk) disable iff (!reset_n)
		status[10:9] == 2'h1 && status[7:0] == 8'hb0)
		else $error("status constant bits wrong");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!reset_n)
		status[6] == 1'b0 && status[3:0] == 4'h0)
		else $error("reserved status bits not zero");
	a_cap_ones: assert property (@(posedge ref_clk) disable iff (!reset_n)
		status[7] && status[5] && status[4])
		else $error("capability bits not one");
	a_class_read: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cfg.rd && cfg.addr == 8'h08 && cfg.be_n == 4'h0 |=> rdata_ff[31:8] == 24'h060400 && rdata_ff[7:0] == REVISION)
		else $error("class dword read wrong");
	a_mdp_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!parity_response_enable_ff && !flags[0] |=> !flags[0])
		else $error("parity flag set while response disabled");
	a_perr_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
		primary_parity_err_oe_ff |-> $past(parity_response_enable_ff) && !primary_parity_err_n_ff)
		else $error("parity line driven while disabled");
	a_serr_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!primary_syserr_n_ff |-> $past(syserr_output_enable_ff) && $past(syserr_request))
		else $error("system error driven while disabled");
	a_serr_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!primary_syserr_n_ff |=> flags[4])
		else $error("system error flag not set");
	a_ma_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pri_is_master && pri_got_ma |=> flags[3])
		else $error("master abort flag not set");
	a_par_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pri_addr_par_err || pri_data_par_err |=> flags[5])
		else $error("detected parity flag not set");
	a_got_ta_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pri_is_master && pri_got_ta |=> flags[2])
		else $error("received target abort flag not set");
	a_gave_ta_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		!pri_is_master && pri_gave_ta |=> flags[1])
		else $error("signaled target abort flag not set");
	a_mdp_flag: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pri_is_master && (pri_data_par_err || pri_perr_seen) && parity_response_enable_ff |=> flags[0])
		else $error("master data parity flag not set");
	a_clr_byte: assert property (@(posedge ref_clk) disable iff (!reset_n)
		cfg.wr && cfg.be_n[3] |-> clr == 6'h00)
		else $error("clear acted on disabled byte");

	c_flag_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
		flags[5] ##1 status_wr && !cfg.be_n[3] && cfg.wdata[31] ##1 !flags[5]);
	c_set_and_clear: cover property (@(posedge ref_clk) disable iff (!reset_n)
		evt.got_ta && clr[2]);
	c_serr_drive: cover property (@(posedge ref_clk) disable iff (!reset_n)
		syserr_output_enable_ff && syserr_request);
	c_class_read: cover property (@(posedge ref_clk) disable iff (!reset_n)
		cfg.rd && cfg.addr == BPSC_OFS_CLASS);
	c_perr_drive: cover property (@(posedge ref_clk) disable iff (!reset_n)
		parity_response_enable_ff && perr_request);
endmodule : bpsc_regs
`default_nettype wire

//--- dv/bpsc_host_model.sv
/*
 Host model that issues configuration reads and writes.
 Assumes one access at a time, launched just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bpsc_host_model
	import bpsc_pkg::*;
(
	// Clock and answer
	input wire logic ref_clk,
	input wire logic [31:0] rdata_ff,
	input wire logic rvalid_ff,
	// Request
	output var bpsc_cfg_t cfg
);
	initial cfg = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, be_n: 4'hf, wdata: 32'h0};

	task automatic access(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge ref_clk);
		cfg <= '{rd: !w, wr: w, addr: a, be_n: b, wdata: d};
		@(posedge ref_clk);
		// Released lanes show the inverse so a stale value is never trusted
		cfg <= '{rd: 1'b0, wr: 1'b0, addr: ~a, be_n: ~b, wdata: ~d};
		#1;
		r = (w || rvalid_ff === 1'b1) ? rdata_ff : ~rdata_ff;
	endtask : access
endmodule : bpsc_host_model
`default_nettype wire

//--- dv/tb_top.sv
/*
 Self-checking bench for the status and class register slice.
 Assumes the host model drives configuration cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top import bpsc_pkg::*; ;
	localparam logic [7:0] REV = 8'h5a; // Arbitrary value
	logic ref_clk, reset_n, master, syserr_rq, perr_rq, pe, se;
	logic syserr_n, syserr_oe, perr_n, perr_oe, rvalid_ff;
	logic [5:0] ev;
	logic [31:0] rdata_ff, rd;
	bpsc_cfg_t cfg;
	int errors = 0;
	int checked = 0;
	bpsc_host_model host (.ref_clk(ref_clk), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .cfg(cfg));
	bpsc_regs #(.REVISION(REV)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .cfg(cfg),
		.rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff), .pri_is_master(master),
		.pri_addr_par_err(ev[5]), .pri_data_par_err(ev[4]), .pri_perr_seen(ev[3]),
		.pri_got_ma(ev[2]), .pri_got_ta(ev[1]), .pri_gave_ta(ev[0]),
		.syserr_request(syserr_rq), .perr_request(perr_rq),
		.primary_syserr_n_ff(syserr_n), .primary_syserr_oe_ff(syserr_oe),
		.primary_parity_err_n_ff(perr_n), .primary_parity_err_oe_ff(perr_oe),
		.parity_response_enable_ff(pe), .syserr_output_enable_ff(se));

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic rw(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		host.access(1'b1, a, b, d, rd);
	endtask : rw
	task automatic rdr(input logic [7:0] a, input logic [3:0] b);
		host.access(1'b0, a, b, 32'h0, rd);
	endtask : rdr
	task automatic rflags(input logic [31:0] x);
		rdr(8'h04, 4'h0);
		chk("flags", rd & 32'hf900_0000, x);
	endtask : rflags
	task automatic pulse(input logic m, input logic [5:0] e);
		@(posedge ref_clk);
		master <= m;
		ev <= e;
		@(posedge ref_clk);
		ev <= 6'h0;
	endtask : pulse
	// Clear every flag, set command bits, raise one event, read the flags back
	task automatic fcase(input logic m, input logic [31:0] c, input logic [5:0] e, input logic [31:0] x);
		rw(8'h04, 4'h0, 32'hf900_0000 | c);
		pulse(m, e);
		rflags(x);
	endtask : fcase
	task automatic pin(input logic [31:0] c, input logic s, input logic p, input logic [3:0] x);
		rw(8'h04, 4'h0, 32'hf900_0000 | c);
		@(posedge ref_clk);
		syserr_rq <= s;
		perr_rq <= p;
		@(posedge ref_clk);
		syserr_rq <= 1'b0;
		perr_rq <= 1'b0;
		#1;
		chk("pins", {28'h0, syserr_oe, syserr_n, perr_oe, perr_n}, {28'h0, x});
		rflags((s && c[8]) ? 32'h4000_0000 : 32'h0);
	endtask : pin

	task automatic t_const;
		rdr(8'h04, 4'h0);
		chk("status", rd, 32'h02b0_0000);
		rdr(8'h08, 4'h0);
		chk("class", rd, {8'h06, 8'h04, 8'h00, REV});
		rw(8'h04, 4'h0, 32'hffff_ffff);
		rw(8'h08, 4'h0, 32'hffff_ffff);
		rdr(8'h04, 4'h0);
		chk("status", rd, 32'h02b0_0140);
		chk("cmd", {30'h0, pe, se}, 32'h3);
		rdr(8'h08, 4'h0);
		chk("class", rd, {8'h06, 8'h04, 8'h00, REV});
		rdr(8'h10, 4'h0);
		chk("unmapped", rd, 32'h0);
		$display("test const done");
	endtask : t_const
	task automatic t_flags;
		fcase(1'b1, 32'h140, 6'h04, 32'h2000_0000);
		fcase(1'b1, 32'h140, 6'h02, 32'h1000_0000);
		fcase(1'b0, 32'h140, 6'h01, 32'h0800_0000);
		fcase(1'b0, 32'h140, 6'h20, 32'h8000_0000);
		fcase(1'b1, 32'h140, 6'h10, 32'h8100_0000);
		fcase(1'b1, 32'h100, 6'h10, 32'h8000_0000);
		fcase(1'b1, 32'h140, 6'h08, 32'h0100_0000);
		fcase(1'b0, 32'h140, 6'h04, 32'h0);
		$display("test flags done");
	endtask : t_flags
	task automatic t_clear;
		fcase(1'b1, 32'h140, 6'h04, 32'h2000_0000);
		rw(8'h04, 4'h8, 32'hf900_0140);
		rflags(32'h2000_0000);
		rw(8'h04, 4'h0, 32'h0000_0140);
		rflags(32'h2000_0000);
		rw(8'h04, 4'h0, 32'h2000_0140);
		rflags(32'h0);
		fork
			rw(8'h04, 4'h0, 32'h2000_0140);
			pulse(1'b1, 6'h04);
		join
		rflags(32'h2000_0000);
		$display("test clear done");
	endtask : t_clear
	task automatic t_pins;
		pin(32'h140, 1'b1, 1'b0, 4'h9);
		pin(32'h140, 1'b0, 1'b1, 4'h6);
		pin(32'h0, 1'b1, 1'b0, 4'h5);
		pin(32'h0, 1'b0, 1'b1, 4'h5);
		$display("test pins done");
	endtask : t_pins

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// About 110 cycles of traffic; the limit leaves wide margin
	initial begin
		#200000;
		errors++;
		final_report();
	end
	initial begin
		reset_n = 1'b0;
		master = 1'b0;
		ev = 6'h0;
		syserr_rq = 1'b0;
		perr_rq = 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		t_const();
		t_flags();
		t_clear();
		t_pins();
		final_report();
	end
endmodule : tb_top
`default_nettype wire
